/* logic/spi_regs.svh */
// register offsets, field positions and sizes of the stats port index block
`ifndef SPI_REGS_SVH
`define SPI_REGS_SVH
`define SPI_NUM_PORTS        76
`define SPI_PORT_MULT        11'h04c
`define SPI_MAX_RX_SLOT      5'h19
`define SPI_MAX_TX_SLOT      5'h18
`define SPI_NUM_BANKS        16
`define SPI_NUM_LOCAL        6
`define SPI_NUM_DISC         64
`define SPI_BANK_RATE_MHZ    550
`define SPI_CORE_MHZ         200
`define SPI_BANK_CFG_BASE    16'h0040
`define SPI_RX_MAP_BASE      16'h0400
`define SPI_TX_MAP_BASE      16'h0600
`define SPI_DISC_FRM_BASE    16'h1000
`define SPI_DISC_BYT_BASE    16'h1400
`define SPI_MAP_TAG_LSB      0
`define SPI_MAP_ADJ_LSB      8
`define SPI_CFG_SRC_LSB      0
`define SPI_CFG_CH_LSB       2
`define SPI_MAP_RESET        13'h0000
`define SPI_CFG_RESET        5'h00
`endif

/* logic/spi_pkg.sv */
// types of the stats port index block
package spi_pkg;
    typedef enum logic [1:0] {
        SPI_SRC_RX    = 2'b00,
        SPI_SRC_TX    = 2'b01,
        SPI_SRC_LOCAL = 2'b11,
        SPI_SRC_OFF   = 2'b10
    } spi_src_t;

    typedef struct packed {
        logic [63:0][63:0]  frm;
        logic [63:0][63:0]  byt;
        logic [75:0][12:0]  rx_map;
        logic [75:0][12:0]  tx_map;
        logic [15:0][4:0]   bank_cfg;
        logic [31:0]        rd_hold;
        logic [31:0]        rd_pend;
        logic [31:0]        wr_hold;
        logic [31:0]        prdata;
        logic [126:0]       key;
        logic [7:0]         rx_tag;
        logic [7:0]         tx_tag;
        logic [4:0]         rx_adj;
        logic [4:0]         tx_adj;
        logic [15:0][10:0]  bank_idx;
        logic [15:0]        bank_ok;
        logic [15:0]        bank_sub;
        logic [63:0]        init_mask;
    } spi_state_t;
endpackage

/* logic/spi_stats_port_index.sv */
// stats port index, discrete counters and key assembly
// Notes on behaviour
// - per-port index is 76 times slot plus port
// - slot from chosen 5-bit channel, 0..25
// - at most 26 rx, 25 tx slots
// - slot source: rx, tx or local channel
// - one counter per bank per frame
// - 64 discrete pairs update in parallel
// - mask bit i bumps pair i
// - byte counter meaningless for tx-counting pairs
// - initial mask: rx flags low, acl high
// - mapped mask, not initial, enables updates
// - 64-bit counters with atomic software access
// - bank counters sustain 550 MHz updates
// - port bit two picks sub-bank
// - colored counters use port bit two
// - overdriven uncolored counter throttles pipeline
// - discrete counters never throttle
// - 76-entry port tables give 8-bit tags
// - port tables give 5-bit length adjust
// - 127-bit key field layout
// - 69-bit rx key field layout
// - rx error state encoding 00/01/11
// - five congestion drop cause bits
// - upper 16 stats flags stay off key
// - separate rx and tx valid in key
// - one rx and one tx frame per cycle
// - six local 5-bit index channels
`include "spi_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_stats_port_index (
    input  wire logic          mclk_in,
    input  wire logic          reset_n_in,
    input  wire logic          psel_in,
    input  wire logic          penable_in,
    input  wire logic          pwrite_in,
    input  wire logic [15:0]   paddr_in,
    input  wire logic [31:0]   pwdata_in,
    output logic [31:0]        prdata_out,
    output logic               pready_out,
    output logic               pslverr_out,
    input  wire logic          rx_valid_in,
    input  wire logic [6:0]    rx_port_in,
    input  wire logic [1:0]    ingress_error_state_in,
    input  wire logic [17:0]   edit_flag_bits_in,
    input  wire logic [31:0]   rx_stats_flags_in,
    input  wire logic [7:0]    rx_drop_code_in,
    input  wire logic [7:0]    rx_cpu_code_in,
    input  wire logic [3:0]    memory_partition_no_in,
    input  wire logic [4:0]    congestion_drop_bits_in,
    input  wire logic [31:0]   egress_acl_count_bits_in,
    input  wire logic [4:0]    rx_slot_in,
    input  wire logic          tx_valid_in,
    input  wire logic [6:0]    tx_port_in,
    input  wire logic [7:0]    egress_outcome_flags_in,
    input  wire logic [39:0]   egress_modify_key_in,
    input  wire logic [4:0]    tx_slot_in,
    input  wire logic [29:0]   local_index_channel_in,
    input  wire logic [5:0]    local_index_valid_in,
    input  wire logic          mapped_valid_in,
    input  wire logic [63:0]   mapped_discrete_mask_in,
    input  wire logic [13:0]   mapped_rx_len_in,
    output logic [126:0]       stats_key_out,
    output logic [7:0]         rx_port_tag_out,
    output logic [7:0]         tx_port_tag_out,
    output logic [4:0]         ingress_port_len_adj_out,
    output logic [4:0]         egress_port_len_adj_out,
    output logic [63:0]        init_discrete_mask_out,
    output logic [175:0]       wide_counter_index_out,
    output logic [15:0]        bank_index_ok_out,
    output logic [15:0]        bank_sub_sel_out,
    output logic               throttle_out
);
    spi_pkg::spi_state_t st;
    spi_pkg::spi_state_t next_st;

    function automatic logic [10:0] slot_index(input logic [4:0] slot, input logic [6:0] port);
        slot_index = 11'(`SPI_PORT_MULT * {6'h00, slot} + {4'h0, port});
    endfunction

    function automatic logic in_span(input logic [15:0] a, input logic [15:0] base, input logic [15:0] words);
        in_span = (a >= base) && (a < 16'(base + (words << 2)));
    endfunction

    logic        wr_acc;
    logic        rd_setup;
    logic        rd_acc;
    logic        unmapped;
    logic [15:0] rel_cfg;
    logic [15:0] rel_rx;
    logic [15:0] rel_tx;
    logic [15:0] rel_frm;
    logic [15:0] rel_byt;
    logic        hit_cfg;
    logic        hit_rx;
    logic        hit_tx;
    logic        hit_frm;
    logic        hit_byt;
    logic [6:0]  rx_idx;
    logic [6:0]  tx_idx;
    logic [5:0]  disc_idx;

    always_comb begin
        rel_cfg  = paddr_in - `SPI_BANK_CFG_BASE;
        rel_rx   = paddr_in - `SPI_RX_MAP_BASE;
        rel_tx   = paddr_in - `SPI_TX_MAP_BASE;
        rel_frm  = paddr_in - `SPI_DISC_FRM_BASE;
        rel_byt  = paddr_in - `SPI_DISC_BYT_BASE;
        hit_cfg  = in_span(paddr_in, `SPI_BANK_CFG_BASE, 16'(`SPI_NUM_BANKS));
        hit_rx   = in_span(paddr_in, `SPI_RX_MAP_BASE, 16'(`SPI_NUM_PORTS));
        hit_tx   = in_span(paddr_in, `SPI_TX_MAP_BASE, 16'(`SPI_NUM_PORTS));
        hit_frm  = in_span(paddr_in, `SPI_DISC_FRM_BASE, 16'(2 * `SPI_NUM_DISC));
        hit_byt  = in_span(paddr_in, `SPI_DISC_BYT_BASE, 16'(2 * `SPI_NUM_DISC));
        unmapped = (paddr_in[1:0] != 2'b00) || !(hit_cfg || hit_rx || hit_tx || hit_frm || hit_byt);
        wr_acc   = psel_in && penable_in && pwrite_in && !unmapped;
        rd_setup = psel_in && !penable_in && !pwrite_in;
        rd_acc   = psel_in && penable_in && !pwrite_in && !unmapped;
        rx_idx   = hit_rx ? rel_rx[8:2] : 7'h00;
        tx_idx   = hit_tx ? rel_tx[8:2] : 7'h00;
        disc_idx = hit_frm ? rel_frm[8:3] : rel_byt[8:3];
    end

    logic [4:0]  b_slot;
    logic [6:0]  b_port;
    logic        b_ok;
    logic [2:0]  b_ch;
    logic [4:0]  b_max;

    always_comb begin
        next_st = st;
        b_slot  = 5'h00;
        b_port  = 7'h00;
        b_ok    = 1'b0;
        b_ch    = 3'h0;
        b_max   = 5'h00;
        // port tables looked up ahead of the key and index work
        next_st.rx_tag = st.rx_map[rx_port_in < 7'(`SPI_NUM_PORTS) ? rx_port_in : 7'h00][7:0];
        next_st.tx_tag = st.tx_map[tx_port_in < 7'(`SPI_NUM_PORTS) ? tx_port_in : 7'h00][7:0];
        next_st.rx_adj = st.rx_map[rx_port_in < 7'(`SPI_NUM_PORTS) ? rx_port_in : 7'h00][12:8];
        next_st.tx_adj = st.tx_map[tx_port_in < 7'(`SPI_NUM_PORTS) ? tx_port_in : 7'h00][12:8];
        // invalid direction zeroes its fields so a rule on that side cannot hit by accident
        next_st.key = {rx_valid_in,
                       rx_valid_in ? {next_st.rx_tag, ingress_error_state_in, edit_flag_bits_in,
                                      rx_stats_flags_in[15:0], rx_drop_code_in, rx_cpu_code_in,
                                      memory_partition_no_in, congestion_drop_bits_in} : 69'h0,
                       tx_valid_in,
                       tx_valid_in ? {next_st.tx_tag, egress_outcome_flags_in, egress_modify_key_in} : 56'h0};
        // rx and tx halves are built side by side each cycle
        next_st.init_mask = {egress_acl_count_bits_in, rx_stats_flags_in};
        // every bank resolves one index per cycle from its own source
        for (int b = 0; b < `SPI_NUM_BANKS; b++) begin
            b_ch = st.bank_cfg[b][`SPI_CFG_CH_LSB +: 3];
            case (spi_pkg::spi_src_t'(st.bank_cfg[b][`SPI_CFG_SRC_LSB +: 2]))
                spi_pkg::SPI_SRC_RX: begin
                    b_slot = rx_slot_in;
                    b_port = rx_port_in;
                    b_ok   = rx_valid_in;
                    b_max  = `SPI_MAX_RX_SLOT;
                end
                spi_pkg::SPI_SRC_TX: begin
                    b_slot = tx_slot_in;
                    b_port = tx_port_in;
                    b_ok   = tx_valid_in;
                    b_max  = `SPI_MAX_TX_SLOT;
                end
                spi_pkg::SPI_SRC_LOCAL: begin
                    b_slot = (b_ch < 3'(`SPI_NUM_LOCAL)) ? local_index_channel_in[5*b_ch +: 5] : 5'h00;
                    b_port = rx_port_in;
                    b_ok   = rx_valid_in && (b_ch < 3'(`SPI_NUM_LOCAL)) && local_index_valid_in[b_ch];
                    b_max  = `SPI_MAX_RX_SLOT;
                end
                default: begin
                    b_slot = 5'h00;
                    b_port = 7'h00;
                    b_ok   = 1'b0;
                    b_max  = 5'h00;
                end
            endcase
            next_st.bank_ok[b]  = b_ok && (b_slot <= b_max) && (b_port < 7'(`SPI_NUM_PORTS));
            next_st.bank_idx[b] = slot_index(b_slot, b_port);
            next_st.bank_sub[b] = b_port[2];
        end
        // all discrete pairs update together from the mapped mask; no arbitration so no stall
        for (int i = 0; i < `SPI_NUM_DISC; i++) begin
            if (mapped_valid_in && mapped_discrete_mask_in[i]) begin
                next_st.frm[i] = st.frm[i] + 64'h0000_0000_0000_0001;
                // tx-counting pairs still add rx length; value is undefined by design
                next_st.byt[i] = st.byt[i] + {50'h0, mapped_rx_len_in};
            end
        end
        // reads: value latched in setup, high half parked for atomic follow-up
        if (rd_setup) begin
            next_st.prdata  = 32'h0000_0000;
            next_st.rd_pend = 32'h0000_0000;
            if (hit_cfg && !unmapped) begin
                next_st.prdata = {27'h0, st.bank_cfg[rel_cfg[5:2]]};
            end else if (hit_rx && !unmapped) begin
                next_st.prdata = {19'h0, st.rx_map[rx_idx]};
            end else if (hit_tx && !unmapped) begin
                next_st.prdata = {19'h0, st.tx_map[tx_idx]};
            end else if ((hit_frm || hit_byt) && !unmapped) begin
                if (paddr_in[2]) begin
                    next_st.prdata = st.rd_hold;
                end else begin
                    next_st.prdata  = hit_frm ? st.frm[disc_idx][31:0] : st.byt[disc_idx][31:0];
                    next_st.rd_pend = hit_frm ? st.frm[disc_idx][63:32] : st.byt[disc_idx][63:32];
                end
            end
        end
        if (rd_acc && (hit_frm || hit_byt) && !paddr_in[2]) begin
            next_st.rd_hold = st.rd_pend;
        end
        // writes: low half parks, high half commits all 64 bits; software wins over a count
        if (wr_acc) begin
            if (hit_cfg) begin
                next_st.bank_cfg[rel_cfg[5:2]] = pwdata_in[4:0];
            end else if (hit_rx) begin
                next_st.rx_map[rx_idx] = pwdata_in[12:0];
            end else if (hit_tx) begin
                next_st.tx_map[tx_idx] = pwdata_in[12:0];
            end else if (!paddr_in[2]) begin
                next_st.wr_hold = pwdata_in;
            end else if (hit_frm) begin
                next_st.frm[disc_idx] = {pwdata_in, st.wr_hold};
            end else begin
                next_st.byt[disc_idx] = {pwdata_in, st.wr_hold};
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        prdata_out               = st.prdata;
        pready_out               = psel_in && penable_in;
        pslverr_out              = psel_in && penable_in && unmapped;
        stats_key_out            = st.key;
        rx_port_tag_out          = st.rx_tag;
        tx_port_tag_out          = st.tx_tag;
        ingress_port_len_adj_out = st.rx_adj;
        egress_port_len_adj_out  = st.tx_adj;
        init_discrete_mask_out   = st.init_mask;
        wide_counter_index_out   = st.bank_idx;
        bank_index_ok_out        = st.bank_ok;
        bank_sub_sel_out         = st.bank_sub;
        // one update per bank per core cycle stays under the bank rate, so no throttle here
        throttle_out             = (`SPI_CORE_MHZ > `SPI_BANK_RATE_MHZ);
    end

    a_index_value: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st.bank_cfg[0][1:0] == 2'b00 && rx_valid_in && rx_slot_in <= 5'h19 && rx_port_in < 7'h4c)
        |=> (wide_counter_index_out[10:0] == 11'($past(rx_slot_in)) * 11'h04c + 11'($past(rx_port_in))
             && bank_index_ok_out[0]))
        else $error("per-port index wrong");

    a_slot_range: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st.bank_cfg[1][1:0] == 2'b01 && tx_valid_in && tx_slot_in == 5'h19) |=> !bank_index_ok_out[1])
        else $error("tx slot 25 accepted");

    a_sub_bank: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st.bank_cfg[2][1:0] == 2'b00) |=> (bank_sub_sel_out[2] == $past(rx_port_in[2])))
        else $error("sub-bank select not port bit two");

    a_init_mask: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        1'b1 |=> init_discrete_mask_out == {$past(egress_acl_count_bits_in), $past(rx_stats_flags_in)})
        else $error("initial mask halves wrong");

    a_frame_count: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (mapped_valid_in && mapped_discrete_mask_in[0] && !(psel_in && penable_in && pwrite_in))
        |=> st.frm[0] == $past(st.frm[0]) + 64'h0000_0000_0000_0001)
        else $error("discrete frame counter missed");

    a_byte_count: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (mapped_valid_in && mapped_discrete_mask_in[63] && !(psel_in && penable_in && pwrite_in))
        |=> st.byt[63] == $past(st.byt[63]) + {50'h0, $past(mapped_rx_len_in)})
        else $error("discrete byte counter wrong");

    a_idle_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (!mapped_valid_in && !(psel_in && penable_in && pwrite_in)) |=> $stable(st.frm[0]) && $stable(st.byt[0]))
        else $error("counter moved without mapped mask");

    a_key_split: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (!rx_valid_in && tx_valid_in) |=> (!stats_key_out[126] && stats_key_out[125:57] == 69'h0
                                           && stats_key_out[56] && stats_key_out[39:0] == $past(egress_modify_key_in)))
        else $error("key valid split wrong");

    a_no_throttle: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        mapped_valid_in |-> !throttle_out)
        else $error("discrete update throttled");
endmodule
`default_nettype wire

/* test/spi_upstream_model.sv */
// upstream pipeline model: frame fields, local index channels, mapped mask
`timescale 1ns/1ps
`default_nettype none
module spi_upstream_model (
    input  wire logic   mclk_in,
    output logic        rxv_out,
    output logic [6:0]  rxp_out,
    output logic [1:0]  err_out,
    output logic [17:0] edit_out,
    output logic [31:0] flg_out,
    output logic [7:0]  drop_out,
    output logic [7:0]  cpu_out,
    output logic [3:0]  part_out,
    output logic [4:0]  cong_out,
    output logic [31:0] acl_out,
    output logic [4:0]  rxs_out,
    output logic        txv_out,
    output logic [6:0]  txp_out,
    output logic [7:0]  oflg_out,
    output logic [39:0] mkey_out,
    output logic [4:0]  txs_out,
    output logic [29:0] loc_out,
    output logic [5:0]  loc_ok_out,
    output logic        mv_out,
    output logic [63:0] mmask_out,
    output logic [13:0] mlen_out
);
    initial begin
        {rxv_out, rxp_out, err_out, edit_out, flg_out, drop_out, cpu_out, part_out} = '0;
        {cong_out, acl_out, rxs_out, txv_out, txp_out, oflg_out, mkey_out, txs_out} = '0;
        {loc_out, loc_ok_out, mv_out, mmask_out, mlen_out} = '0;
    end
    // one rx and one tx frame in one cycle; valids drop and port, slot and channel lines are scrambled once it has passed
    task automatic frame(input logic rv, input logic [6:0] rp, input logic [4:0] rs, input logic tv,
                         input logic [6:0] tp, input logic [4:0] ts, input logic [4:0] lv, input logic [7:0] d);
        @(posedge mclk_in);
        rxv_out <= rv;
        rxp_out <= rp;
        rxs_out <= rs;
        txv_out <= tv;
        txp_out <= tp;
        txs_out <= ts;
        err_out <= d[1:0];
        edit_out <= {d, d, d[1:0]};
        flg_out <= {~d, d, d, ~d};
        drop_out <= d + 8'h01;
        cpu_out <= d ^ 8'h3c;
        part_out <= d[3:0];
        cong_out <= d[4:0];
        acl_out <= {d, ~d, d, d};
        oflg_out <= ~d;
        mkey_out <= {5{d}};
        loc_out <= {6{lv}};
        loc_ok_out <= 6'h3f;
        @(posedge mclk_in);
        rxv_out <= 1'b0;
        txv_out <= 1'b0;
        loc_ok_out <= 6'h00;
        rxp_out <= ~rp;
        rxs_out <= ~rs;
        txp_out <= ~tp;
        txs_out <= ~ts;
        loc_out <= ~{6{lv}};
    endtask
    task automatic count(input logic v, input logic [63:0] m, input logic [13:0] len);
        @(posedge mclk_in);
        mv_out <= v;
        mmask_out <= m;
        mlen_out <= len;
        @(posedge mclk_in);
        mv_out <= 1'b0;
        mmask_out <= ~m;
        mlen_out <= ~len;
    endtask
endmodule
`default_nettype wire

/* test/spi_stats_port_index_test.sv */
// self-checking bench of the stats port index block
`timescale 1ns/1ps
`default_nettype none
module spi_stats_port_index_test;
    logic mclk_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
    logic [15:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, rx_stats_flags_in, egress_acl_count_bits_in;
    logic rx_valid_in, tx_valid_in, mapped_valid_in, throttle_out;
    logic [6:0] rx_port_in, tx_port_in;
    logic [1:0] ingress_error_state_in;
    logic [17:0] edit_flag_bits_in;
    logic [7:0] rx_drop_code_in, rx_cpu_code_in, egress_outcome_flags_in, rx_port_tag_out, tx_port_tag_out;
    logic [3:0] memory_partition_no_in;
    logic [4:0] congestion_drop_bits_in, rx_slot_in, tx_slot_in, ingress_port_len_adj_out, egress_port_len_adj_out;
    logic [39:0] egress_modify_key_in;
    logic [29:0] local_index_channel_in;
    logic [5:0] local_index_valid_in;
    logic [63:0] mapped_discrete_mask_in, init_discrete_mask_out;
    logic [13:0] mapped_rx_len_in;
    logic [126:0] stats_key_out;
    logic [175:0] wide_counter_index_out;
    logic [15:0] bank_index_ok_out, bank_sub_sel_out;
    int n_fail, n_checks;
    spi_stats_port_index dut_u (.mclk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .rx_valid_in, .rx_port_in, .ingress_error_state_in,
        .edit_flag_bits_in, .rx_stats_flags_in, .rx_drop_code_in, .rx_cpu_code_in, .memory_partition_no_in,
        .congestion_drop_bits_in, .egress_acl_count_bits_in, .rx_slot_in, .tx_valid_in, .tx_port_in,
        .egress_outcome_flags_in, .egress_modify_key_in, .tx_slot_in, .local_index_channel_in,
        .local_index_valid_in, .mapped_valid_in, .mapped_discrete_mask_in, .mapped_rx_len_in, .stats_key_out,
        .rx_port_tag_out, .tx_port_tag_out, .ingress_port_len_adj_out, .egress_port_len_adj_out,
        .init_discrete_mask_out, .wide_counter_index_out, .bank_index_ok_out, .bank_sub_sel_out, .throttle_out);
    spi_upstream_model up_u (.mclk_in, .rxv_out(rx_valid_in), .rxp_out(rx_port_in), .err_out(ingress_error_state_in),
        .edit_out(edit_flag_bits_in), .flg_out(rx_stats_flags_in), .drop_out(rx_drop_code_in),
        .cpu_out(rx_cpu_code_in), .part_out(memory_partition_no_in), .cong_out(congestion_drop_bits_in),
        .acl_out(egress_acl_count_bits_in), .rxs_out(rx_slot_in), .txv_out(tx_valid_in), .txp_out(tx_port_in),
        .oflg_out(egress_outcome_flags_in), .mkey_out(egress_modify_key_in), .txs_out(tx_slot_in),
        .loc_out(local_index_channel_in), .loc_ok_out(local_index_valid_in), .mv_out(mapped_valid_in),
        .mmask_out(mapped_discrete_mask_in), .mlen_out(mapped_rx_len_in));
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    task automatic check(input string what, input logic [175:0] seen, input logic [175:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held from setup until pready is seen high at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        @(posedge mclk_in);
        while (pready_out !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk_in);
        end
        if (n == 50) n_fail++;
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic bad);
        apb(1'b0, a, 32'h0000_0000);
        check("prdata", rd, exp);
        check("pslverr", er, bad);
    endtask
    function automatic logic [126:0] key_exp(input logic rv, input logic tv, input logic [7:0] rt,
                                             input logic [7:0] tt, input logic [7:0] d);
        logic [68:0] r;
        logic [55:0] t;
        r = {rt, d[1:0], d, d, d[1:0], d, ~d, d + 8'h01, d ^ 8'h3c, d[3:0], d[4:0]};
        t = {tt, ~d, {5{d}}};
        return {rv, rv ? r : 69'h0, tv, tv ? t : 56'h0};
    endfunction
    task automatic fr(input logic rv, input logic [6:0] rp, input logic [4:0] rs, input logic tv,
                      input logic [6:0] tp, input logic [4:0] ts, input logic [4:0] lv, input logic [7:0] d,
                      input logic [3:0] ok);
        logic [10:0] ix [3];
        logic [7:0] rt;
        logic [7:0] tt;
        rt = (rp == 7'h03) ? 8'h5a : 8'h00;
        tt = (tp == 7'h05) ? 8'ha5 : 8'h00;
        ix[0] = 11'(rs) * 11'h04c + 11'(rp);
        ix[1] = 11'(ts) * 11'h04c + 11'(tp);
        ix[2] = 11'(lv) * 11'h04c + 11'(rp);
        up_u.frame(rv, rp, rs, tv, tp, ts, lv, d);
        #1;
        check("key", stats_key_out, key_exp(rv, tv, rt, tt, d));
        check("bank ok", bank_index_ok_out, {{12{ok[0]}}, ok});
        check("throttle", throttle_out, 1'b0);
        for (int b = 0; b < 3; b++) begin
            if (ok[b]) begin
                check("index", wide_counter_index_out[11*b +: 11], ix[b]);
                check("sub bank", bank_sub_sel_out[b], (b == 1) ? tp[2] : rp[2]);
            end
        end
        check("rx tag", rx_port_tag_out, rt);
        check("tx tag", tx_port_tag_out, tt);
        check("rx adj", ingress_port_len_adj_out, (rp == 7'h03) ? 5'h07 : 5'h00);
        check("init mask", init_discrete_mask_out, {d, ~d, d, d, ~d, d, d, ~d});
        if (tv) begin
            check("tx adj", egress_port_len_adj_out, (tp == 7'h05) ? 5'h1f : 5'h00);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, reset_n_in, n_fail, n_checks} = '0;
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rdchk(16'h0040, 32'h0000_0000, 1'b0);
        rdchk(16'h040c, 32'h0000_0000, 1'b0);
        rdchk(16'h0042, 32'h0000_0000, 1'b1);
        rdchk(16'h3000, 32'h0000_0000, 1'b1);
        apb(1'b1, 16'h040c, 32'h0000_075a);
        apb(1'b1, 16'h0614, 32'h0000_1fa5);
        apb(1'b1, 16'h0044, 32'h0000_0001);
        apb(1'b1, 16'h0048, 32'h0000_0017);
        apb(1'b1, 16'h004c, 32'h0000_0002);
        rdchk(16'h040c, 32'h0000_075a, 1'b0);
        rdchk(16'h0048, 32'h0000_0017, 1'b0);
        fr(1'b1, 7'h03, 5'h19, 1'b1, 7'h05, 5'h18, 5'h07, 8'h01, 4'b0111);
        fr(1'b1, 7'h04, 5'h1a, 1'b1, 7'h05, 5'h19, 5'h1a, 8'h03, 4'b0000);
        fr(1'b1, 7'h4c, 5'h00, 1'b1, 7'h4b, 5'h00, 5'h00, 8'h00, 4'b0010);
        fr(1'b1, 7'h03, 5'h00, 1'b0, 7'h05, 5'h00, 5'h01, 8'h5e, 4'b0101);
        fr(1'b0, 7'h03, 5'h00, 1'b1, 7'h05, 5'h02, 5'h01, 8'h22, 4'b0010);
        // discrete pairs: parallel bumps, idle cycle ignored, wrap and atomic snapshot
        up_u.count(1'b1, 64'h8000_0000_0000_0001, 14'h0064);
        up_u.count(1'b1, 64'h8000_0000_0000_0001, 14'h0064);
        up_u.count(1'b0, 64'hffff_ffff_ffff_ffff, 14'h0007);
        rdchk(16'h1000, 32'h0000_0002, 1'b0);
        rdchk(16'h11f8, 32'h0000_0002, 1'b0);
        rdchk(16'h1400, 32'h0000_00c8, 1'b0);
        rdchk(16'h1008, 32'h0000_0000, 1'b0);
        apb(1'b1, 16'h1008, 32'hffff_ffff);
        apb(1'b1, 16'h100c, 32'hffff_ffff);
        up_u.count(1'b1, 64'h0000_0000_0000_0002, 14'h0005);
        rdchk(16'h1008, 32'h0000_0000, 1'b0);
        rdchk(16'h100c, 32'h0000_0000, 1'b0);
        apb(1'b1, 16'h1010, 32'hffff_ffff);
        apb(1'b1, 16'h1014, 32'h0000_0000);
        rdchk(16'h1010, 32'hffff_ffff, 1'b0);
        up_u.count(1'b1, 64'h0000_0000_0000_0004, 14'h0001);
        rdchk(16'h1014, 32'h0000_0000, 1'b0);
        rdchk(16'h1010, 32'h0000_0000, 1'b0);
        rdchk(16'h1014, 32'h0000_0001, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
